// ==== bit_logic_pkg.sv ====
// Purpose: Shared types and constants for the bit logic stack evaluator
// Assumes: One clock, synchronous active-high reset
// Notes:   Opcode and area encodings are internal choices
package bit_logic_pkg;

   // Logic stack depth and widths
   localparam int STACK_DEPTH = 32;
   localparam int ADDR_W      = 12;
   localparam int PIN_COUNT   = 32;
   localparam int PIN_W       = 5;
   localparam int MAX_TERMS   = 31;
   localparam int TERM_W      = 5;

   // Top of stack index
   localparam int TOP_LEVEL   = 0;

   // Stack reset value
   localparam logic [STACK_DEPTH-1:0] STACK_RESET = 32'h0000_0000;

   // Bit operand areas
   typedef enum logic [3:0] {
      AREA_INPUT_IMAGE,
      AREA_OUTPUT_IMAGE,
      AREA_VARIABLE,
      AREA_FLAG,
      AREA_SPECIAL,
      AREA_TIMER,
      AREA_COUNTER,
      AREA_SEQUENCE,
      AREA_LOCAL
   } area_e;

   // Contact operations
   typedef enum logic [3:0] {
      OP_LOAD_BIT,
      OP_AND_BIT,
      OP_OR_BIT,
      OP_LOAD_INVERTED_BIT,
      OP_AND_INVERTED_BIT,
      OP_OR_INVERTED_BIT,
      OP_LOAD_PIN_NOW,
      OP_AND_PIN_NOW,
      OP_OR_PIN_NOW,
      OP_LOAD_INVERTED_PIN_NOW,
      OP_AND_INVERTED_PIN_NOW,
      OP_OR_INVERTED_PIN_NOW
   } contact_op_e;

   // Merge kind of a contact
   typedef enum logic [1:0] {
      MERGE_LOAD,
      MERGE_AND,
      MERGE_OR
   } merge_e;

   // One instruction from the program stream
   typedef struct packed {
      contact_op_e           op;
      area_e                 area;
      logic [ADDR_W-1:0]     addr;
   } instr_s;

   // Bit memory read request
   typedef struct packed {
      area_e                 area;
      logic [ADDR_W-1:0]     addr;
   } mem_req_s;

endpackage

// ==== contact_decode.sv ====
// Purpose: Splits a contact opcode into merge kind, inversion and source
// Assumes: Pure combinational, fed by the evaluator
// Notes:   Immediate forms select the pin path
`timescale 1ns/1ns
module contact_decode (
   // Opcode in
   input  bit_logic_pkg::contact_op_e op_in,
   // Decoded fields out
   output bit_logic_pkg::merge_e      merge_out,
   output logic                       invert_out,
   output logic                       pin_now_out
);
   import bit_logic_pkg::*;

   // Opcode to fields
   always_comb begin
      merge_out   = MERGE_LOAD;
      invert_out  = 1'b0;
      pin_now_out = 1'b0;
      case (op_in)
         OP_LOAD_BIT: begin
            merge_out = MERGE_LOAD;
         end
         OP_AND_BIT: begin
            merge_out = MERGE_AND;
         end
         OP_OR_BIT: begin
            merge_out = MERGE_OR;
         end
         OP_LOAD_INVERTED_BIT: begin
            merge_out  = MERGE_LOAD;
            invert_out = 1'b1;
         end
         OP_AND_INVERTED_BIT: begin
            merge_out  = MERGE_AND;
            invert_out = 1'b1;
         end
         OP_OR_INVERTED_BIT: begin
            merge_out  = MERGE_OR;
            invert_out = 1'b1;
         end
         OP_LOAD_PIN_NOW: begin
            merge_out   = MERGE_LOAD;
            pin_now_out = 1'b1;
         end
         OP_AND_PIN_NOW: begin
            merge_out   = MERGE_AND;
            pin_now_out = 1'b1;
         end
         OP_OR_PIN_NOW: begin
            merge_out   = MERGE_OR;
            pin_now_out = 1'b1;
         end
         OP_LOAD_INVERTED_PIN_NOW: begin
            merge_out   = MERGE_LOAD;
            invert_out  = 1'b1;
            pin_now_out = 1'b1;
         end
         OP_AND_INVERTED_PIN_NOW: begin
            merge_out   = MERGE_AND;
            invert_out  = 1'b1;
            pin_now_out = 1'b1;
         end
         OP_OR_INVERTED_PIN_NOW: begin
            merge_out   = MERGE_OR;
            invert_out  = 1'b1;
            pin_now_out = 1'b1;
         end
         default: begin
            merge_out = MERGE_LOAD;
         end
      endcase
   end

endmodule

// ==== pin_sync.sv ====
// Purpose: Two-flop synchroniser for the physical input pins
// Assumes: Pins are asynchronous to clk_in
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Raw pins in, synchronised out
   input  wire logic [WIDTH-1:0] pins_in,
   output logic      [WIDTH-1:0] pins_out
);

   logic [WIDTH-1:0] meta_q;  // First stage

   // Two flip-flop chain
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_q   <= '0;
         pins_out <= '0;
      end else begin
         meta_q   <= pins_in;
         pins_out <= meta_q;
      end
   end

endmodule

// ==== bit_logic_stack_evaluator.sv ====
// Purpose: Evaluates contact instructions against a one-bit logic stack
// Assumes: Bit memory answers reads combinationally in the same cycle
// Notes:   One instruction per cycle; pins pass a two-flop synchroniser
`timescale 1ns/1ns

// Operation
// - Bit tests read memory areas or images
// - Load replaces top; AND/OR merge with top
// - Negated forms invert the bit first
// - Normally-open closes when bit is one
// - Normally-closed closes when bit is zero
// - Power passes only if arriving and closed
// - Immediate forms read pins, image untouched
// - Immediate normally-open closes on pin one
// - Immediate normally-closed closes on pin zero
// - Immediate forms merge pin value with top
// - Negated immediate forms invert the pin
// - Gate evaluation accepts up to 31 terms
// - Stack holds 32 one-bit levels
// - Load pushes down, bottom level lost
module bit_logic_stack_evaluator #(
   parameter int DEPTH = bit_logic_pkg::STACK_DEPTH,
   parameter int PINS  = bit_logic_pkg::PIN_COUNT
) (
   // Clock and reset
   input  wire logic                         clk_in,
   input  wire logic                         rst_in,
   // Instruction stream
   input  wire logic                         instr_valid_in,
   input  wire bit_logic_pkg::instr_s        instr_in,
   input  wire logic                         gate_start_in,
   output logic                              instr_ready_out,
   // Bit memory read port
   output bit_logic_pkg::mem_req_s           mem_req_out,
   input  wire logic                         mem_bit_in,
   // Physical input pins
   input  wire logic [PINS-1:0]              pins_in,
   // Results
   output logic                              top_out,
   output logic [DEPTH-1:0]                  stack_out,
   output logic                              contact_closed_out,
   output logic                              done_out,
   output logic [bit_logic_pkg::TERM_W-1:0]  term_count_out,
   output logic                              term_error_out,
   output logic                              pin_error_out
);
   import bit_logic_pkg::*;

   // Decoded instruction fields
   merge_e            merge_w;       // Load, AND or OR
   logic              invert_w;      // Negated form
   logic              pin_now_w;     // Immediate form
   logic [PINS-1:0]   pins_sync_w;   // Synchronised pins
   logic              pin_legal_w;   // Immediate operand is a pin
   logic              raw_bit_w;     // Operand before inversion
   logic              contact_w;     // Closed state of the contact
   logic              fire_w;        // Instruction accepted
   logic [DEPTH-1:0]  stack_d;       // Next stack
   logic [DEPTH-1:0]  stack_q;       // Logic stack, index 0 on top
   logic [TERM_W-1:0] terms_q;       // Terms in current gate
   logic [TERM_W-1:0] terms_d;       // Next term count

   // Opcode decoder
   contact_decode u_decode (
      .op_in       (instr_in.op),
      .merge_out   (merge_w),
      .invert_out  (invert_w),
      .pin_now_out (pin_now_w)
   );

   // Pin synchroniser
   pin_sync #(
      .WIDTH (PINS)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .pins_in  (pins_in),
      .pins_out (pins_sync_w)
   );

   // Apply a contact to a current top value
   // Load simply takes the contact value
   function automatic logic merge_fn(input merge_e m, input logic top,
                                     input logic b);
      case (m)
         MERGE_AND: merge_fn = top & b;
         MERGE_OR:  merge_fn = top | b;
         default:   merge_fn = b;
      endcase
   endfunction

   // Always ready, one instruction per cycle
   assign instr_ready_out = 1'b1;
   assign fire_w          = instr_valid_in;

   // Memory read request follows the instruction
   assign mem_req_out.area = instr_in.area;
   assign mem_req_out.addr = instr_in.addr;

   // Immediate operand must address a real pin in the input image
   // Other areas and addresses past the pin count read as zero
   // and raise pin_error_out instead of aliasing onto a real pin
   assign pin_legal_w = (instr_in.area == AREA_INPUT_IMAGE) &&
                        (instr_in.addr < ADDR_W'(PINS));

   // Operand source select
   // Immediate forms bypass the memory port; no image is written
   // here, so the image keeps its value
   always_comb begin
      raw_bit_w = mem_bit_in;
      if (pin_now_w) begin
         raw_bit_w = pin_legal_w ?
            pins_sync_w[instr_in.addr[PIN_W-1:0]] : 1'b0;
      end
   end

   // Contact closed: open form on 1, closed form on 0
   assign contact_w = raw_bit_w ^
                      invert_w;

   // Next stack value
   // A load shifts every level down one; the bottom bit falls off
   // AND and OR change only the top level
   always_comb begin
      stack_d = stack_q;
      if (merge_w == MERGE_LOAD) begin
         stack_d = {stack_q[DEPTH-2:0], contact_w};
      end else begin
         stack_d[TOP_LEVEL] =
            merge_fn(merge_w, stack_q[TOP_LEVEL], contact_w);
      end
   end

   // Logic stack register
   // Holds its value while no instruction is accepted
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stack_q <= STACK_RESET;
      end else if (fire_w) begin
         stack_q <= stack_d;
      end
   end

   // Gate term counter
   // Count saturates at the limit so a runaway gate cannot wrap
   // to a small value and hide the overflow
   always_comb begin
      terms_d = terms_q;
      if (gate_start_in || merge_w == MERGE_LOAD) begin
         terms_d = TERM_W'(1);
      end else if (terms_q != TERM_W'(MAX_TERMS)) begin
         terms_d = terms_q + TERM_W'(1);
      end
   end

   // Term count register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         terms_q <= '0;
      end else if (fire_w) begin
         terms_q <= terms_d;
      end
   end

   // Status flags per instruction
   // Pulses last one cycle; the stack holds until the next fire
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         done_out           <= 1'b0;
         contact_closed_out <= 1'b0;
         term_error_out     <= 1'b0;
         pin_error_out      <= 1'b0;
      end else begin
         done_out           <= fire_w;
         contact_closed_out <= fire_w & contact_w;
         // More than 31 terms in one gate
         term_error_out     <= fire_w & ~gate_start_in &
                               (merge_w != MERGE_LOAD) &
                               (terms_q == TERM_W'(MAX_TERMS));
         pin_error_out      <= fire_w & pin_now_w & ~pin_legal_w;
      end
   end

   // Outputs from registers; power flow is the top level
   // top_out is the power flow handed to the next element
   assign top_out        = stack_q[TOP_LEVEL];
   assign stack_out      = stack_q;
   assign term_count_out = terms_q;

   // Checks
   // Each property looks one cycle after its trigger: an accepted instruction, reset or an idle cycle
   // Operand values are taken through $past so the check sees what
   // the contact really read, not what the bus shows a cycle later
   chk_load_push: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && merge_w == MERGE_LOAD |=>
      stack_q[DEPTH-1:1] == $past(stack_q[DEPTH-2:0]))
      else $error("load did not push the stack");

   chk_load_top: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && merge_w == MERGE_LOAD && !pin_now_w |=>
      top_out == ($past(mem_bit_in) ^ $past(invert_w)))
      else $error("load top wrong");

   chk_and_merge: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && merge_w == MERGE_AND |=>
      top_out == ($past(stack_q[TOP_LEVEL]) & $past(contact_w)))
      else $error("AND merge wrong");

   chk_or_merge: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && merge_w == MERGE_OR |=>
      top_out == ($past(stack_q[TOP_LEVEL]) | $past(contact_w)))
      else $error("OR merge wrong");

   chk_merge_keeps: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && merge_w != MERGE_LOAD |=>
      stack_q[DEPTH-1:1] == $past(stack_q[DEPTH-1:1]))
      else $error("merge disturbed lower levels");

   chk_inv_closed: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && invert_w && !pin_now_w && !mem_bit_in |=>
      contact_closed_out)
      else $error("inverted contact not closed on zero");

   chk_open_closed: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && !invert_w && !pin_now_w |=>
      contact_closed_out == $past(mem_bit_in))
      else $error("open contact state wrong");

   chk_pin_now: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && pin_now_w && pin_legal_w |=>
      contact_closed_out == ($past(pins_sync_w[instr_in.addr[PIN_W-1:0]])
                             ^ $past(invert_w)))
      else $error("immediate contact wrong");

   chk_pin_inv: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && pin_now_w && invert_w && pin_legal_w &&
      !pins_sync_w[instr_in.addr[PIN_W-1:0]] |=> contact_closed_out)
      else $error("inverted pin contact not closed on zero");

   chk_pin_and: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && pin_now_w && merge_w == MERGE_AND && pin_legal_w |=>
      top_out == ($past(stack_q[TOP_LEVEL]) &
                  ($past(pins_sync_w[instr_in.addr[PIN_W-1:0]]) ^
                   $past(invert_w))))
      else $error("immediate AND merge wrong");

   chk_pin_flag: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && pin_now_w && !pin_legal_w |=>
      pin_error_out && contact_closed_out == $past(invert_w))
      else $error("non-pin operand not flagged");

   chk_reset_clear: assert property (
      @(posedge clk_in)
      rst_in |=> stack_q == STACK_RESET)
      else $error("stack not cleared by reset");

   chk_term_clamp: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && !gate_start_in && merge_w != MERGE_LOAD &&
      terms_q == TERM_W'(MAX_TERMS) |=>
      terms_q == TERM_W'(MAX_TERMS) && term_error_out)
      else $error("term count did not clamp at limit");

   chk_term_restart: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w && (gate_start_in || merge_w == MERGE_LOAD) |=>
      terms_q == TERM_W'(1) && !term_error_out)
      else $error("new gate did not restart the count");

   chk_idle_hold: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !fire_w |=> $stable(stack_q) && !done_out && !contact_closed_out)
      else $error("stack moved or pulsed without an instruction");

   chk_done_pulse: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_w |=> done_out)
      else $error("done pulse missing");

   // Main scenarios the bench should reach
   cov_load:    cover property (@(posedge clk_in)
      fire_w && merge_w == MERGE_LOAD);
   cov_term_over: cover property (@(posedge clk_in)
      fire_w && merge_w != MERGE_LOAD && terms_q == TERM_W'(MAX_TERMS));
   cov_pin_now: cover property (@(posedge clk_in)
      fire_w && pin_now_w && invert_w);
   cov_and_or:  cover property (@(posedge clk_in)
      fire_w && merge_w == MERGE_AND ##1 fire_w && merge_w == MERGE_OR);
   cov_terms:   cover property (@(posedge clk_in)
      terms_q == TERM_W'(MAX_TERMS));

endmodule

// ==== bit_memory_model.sv ====
// Purpose: Bit memory model that answers the evaluator's read port
// Assumes: Reads are answered combinationally in the same cycle
// Notes:   Every area answers; odd addresses hold one, even hold zero
`timescale 1ns/1ns
module bit_memory_model (
   // Read request in
   input  wire bit_logic_pkg::mem_req_s req_in,
   // Addressed bit out
   output logic                         bit_out
);
   import bit_logic_pkg::*;

   // Same pattern in every area, so the bench can predict any read
   assign bit_out = req_in.addr[0];
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the bit logic stack evaluator
// Assumes: Inputs change on the falling edge; outputs settle by then
// Notes:   Expected stack, term count and flags are tracked here
`timescale 1ns/1ns
module testbench;
   import bit_logic_pkg::*;
   // Clock, reset and stimulus
   logic              clk_in;
   logic              rst_in;
   logic              instr_valid_in;
   logic              gate_start_in;
   instr_s            instr_in;
   logic [31:0]       pins_in;
   // Design outputs and memory answer
   mem_req_s          mem_req;
   logic              mem_bit;
   logic              ready;
   logic              top_out;
   logic [31:0]       stack_out;
   logic              closed;
   logic              done;
   logic [TERM_W-1:0] term_cnt;
   logic              term_err;
   logic              pin_err;
   // Expected state and counters
   logic [31:0]       exp_stk;
   int                exp_terms;
   int                error_cnt;
   int                tests_run;

   // Device under test
   bit_logic_stack_evaluator i_bit_logic_stack_evaluator (
      .clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
      .instr_in(instr_in), .gate_start_in(gate_start_in),
      .instr_ready_out(ready), .mem_req_out(mem_req), .mem_bit_in(mem_bit),
      .pins_in(pins_in), .top_out(top_out), .stack_out(stack_out),
      .contact_closed_out(closed), .done_out(done),
      .term_count_out(term_cnt), .term_error_out(term_err),
      .pin_error_out(pin_err)
   );
   // Far-side bit memory
   bit_memory_model i_bit_memory_model (
      .req_in(mem_req),
      .bit_out(mem_bit)
   );

   // Free-running clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // One comparison, reported on mismatch
   task automatic check(string name, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Verdict and end of run
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One instruction, driven now and judged at the next falling edge
   task automatic exec(contact_op_e op, area_e ar, logic [11:0] ad,
                       logic g);
      int   k;
      logic imm;
      logic legal;
      logic b;
      logic v;
      logic restart;
      logic terr;
      k       = int'(op);
      imm     = (k >= 6);
      legal   = (ar == AREA_INPUT_IMAGE) && (ad < 12'h020);
      b       = imm ? (legal ? pins_in[ad[4:0]] : 1'b0) : ad[0];
      v       = b ^ ((k % 6) >= 3);
      restart = ((k % 3) == 0) || g;
      terr    = !restart && (exp_terms == MAX_TERMS);
      instr_valid_in = 1'b1;
      gate_start_in  = g;
      instr_in       = '{op: op, area: ar, addr: ad};
      #1;
      check("mem_req", 32'({ar, ad}), 32'(mem_req));
      check("ready", 32'h0000_0001, 32'(ready));
      // Predicted stack after the edge
      case (k % 3)
         0: exp_stk = {exp_stk[30:0], v};
         1: exp_stk[0] = exp_stk[0] & v;
         default: exp_stk[0] = exp_stk[0] | v;
      endcase
      if (restart) begin
         exp_terms = 1;
      end else if (exp_terms < MAX_TERMS) begin
         exp_terms++;
      end
      @(negedge clk_in);
      check("done", 32'h0000_0001, 32'(done));
      check("closed", 32'(v), 32'(closed));
      check("top", 32'(exp_stk[0]), 32'(top_out));
      check("stack", exp_stk, stack_out);
      check("terms", 32'(exp_terms), 32'(term_cnt));
      check("term_err", 32'(terr), 32'(term_err));
      check("pin_err", 32'(imm && !legal), 32'(pin_err));
   endtask

   // Bus idle for one cycle, no result pulse expected
   task automatic idle();
      instr_valid_in = 1'b0;
      gate_start_in  = 1'b0;
      @(negedge clk_in);
      check("done_idle", 32'h0000_0000, 32'(done));
   endtask

   // Reset leaves an empty stack
   task automatic t_reset();
      check("stack_rst", 32'h0000_0000, stack_out);
      check("top_rst", 32'h0000_0000, 32'(top_out));
      check("done_rst", 32'h0000_0000, 32'(done));
      $display("test reset done");
   endtask

   // Memory forms, every area, both top and operand values
   task automatic t_mem_ops();
      for (int i = 0; i < 6; i++) begin
         for (int t = 0; t < 2; t++) begin
            for (int b = 0; b < 2; b++) begin
               exec(OP_LOAD_BIT, AREA_FLAG, 12'(t), 1'b0);
               exec(contact_op_e'(i), area_e'(i + 3 * b),
                    12'(16 * i + b), 1'b0);
            end
         end
      end
      idle();
      $display("test memory forms done");
   endtask

   // Pin forms read the pins, not memory; pin differs from memory bit
   task automatic t_pin_ops();
      pins_in = 32'hA5A5_0F0F;
      repeat (3) @(negedge clk_in);
      for (int i = 6; i < 12; i++) begin
         for (int t = 0; t < 2; t++) begin
            exec(OP_LOAD_BIT, AREA_VARIABLE, 12'(t), 1'b0);
            exec(contact_op_e'(i), AREA_INPUT_IMAGE, 12'h0000, 1'b0);
            exec(contact_op_e'(i), AREA_INPUT_IMAGE, 12'h0005, 1'b0);
         end
      end
      idle();
      $display("test pin forms done");
   endtask

   // Pin forms with operands that are not pins
   task automatic t_pin_err();
      exec(OP_LOAD_BIT, AREA_FLAG, 12'h0001, 1'b0);
      exec(OP_LOAD_PIN_NOW, AREA_VARIABLE, 12'h0001, 1'b0);
      exec(OP_OR_PIN_NOW, AREA_INPUT_IMAGE, 12'h0020, 1'b0);
      idle();
      $display("test pin operand errors done");
   endtask

   // Gate of 31 terms, then one term too many, then a fresh gate
   task automatic t_terms();
      exec(OP_LOAD_BIT, AREA_FLAG, 12'h0001, 1'b1);
      for (int i = 0; i < 31; i++) begin
         exec(OP_AND_BIT, AREA_FLAG, 12'h0001, 1'b0);
      end
      exec(OP_OR_INVERTED_BIT, AREA_TIMER, 12'h0002, 1'b1);
      exec(OP_OR_BIT, AREA_COUNTER, 12'h0000, 1'b0);
      idle();
      $display("test gate terms done");
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_in);
      error_cnt++;
      $display("BAD watchdog expected finish seen timeout");
      end_of_test();
   end

   // Main sequence
   initial begin
      rst_in         = 1'b1;
      instr_valid_in = 1'b0;
      gate_start_in  = 1'b0;
      instr_in       = '0;
      pins_in        = 32'h0000_0000;
      exp_stk        = 32'h0000_0000;
      exp_terms      = 0;
      error_cnt      = 0;
      tests_run      = 0;
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      @(negedge clk_in);
      t_reset();
      t_mem_ops();
      t_pin_ops();
      t_pin_err();
      t_terms();
      end_of_test();
   end
endmodule
